//--- rtl/scr_pkg.sv
// Constants, register map, field layout and carrier types for the supervisor control registers.
// Assumes a single clock domain and a 32-bit AHB-Lite bus with byte addresses.
`default_nettype none

package scr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map: byte offsets inside the slave window.
    localparam logic [7:0] SCR_OFF_STATUS = 8'h00;
    localparam logic [7:0] SCR_OFF_INT_SP = 8'h04;
    localparam logic [7:0] SCR_OFF_MST_SP = 8'h08;
    localparam logic [7:0] SCR_OFF_USR_SP = 8'h0c;
    localparam logic [7:0] SCR_OFF_VBASE  = 8'h10;
    localparam logic [7:0] SCR_OFF_SRC_FC = 8'h14;
    localparam logic [7:0] SCR_OFF_DST_FC = 8'h18;

    ////////////////////////////////////////////////////////////////////////////////
    // Status register field positions, write mask and reset value.
    localparam int unsigned SCR_ST_TRACE_HI = 15;
    localparam int unsigned SCR_ST_TRACE_LO = 14;
    localparam int unsigned SCR_ST_SUPER    = 13;
    localparam int unsigned SCR_ST_MASTER   = 12;
    localparam int unsigned SCR_ST_IPM_LSB  = 8;
    localparam logic [15:0] SCR_ST_MASK     = 16'hf71f;
    localparam logic [15:0] SCR_ST_RESET    = 16'h2700;

    // Reset values of the wide registers and the function code registers.
    localparam logic [31:0] SCR_SP_RESET    = 32'h0000_0000;
    localparam logic [31:0] SCR_VBASE_RESET = 32'h0000_0000;
    localparam logic [2:0]  SCR_FC_RESET  = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Function codes chosen automatically for normal accesses.
    localparam logic [2:0] SCR_FC_USER_DATA  = 3'h1;
    localparam logic [2:0] SCR_FC_USER_PROG  = 3'h2;
    localparam logic [2:0] SCR_FC_SUPER_DATA = 3'h5;
    localparam logic [2:0] SCR_FC_SUPER_PROG = 3'h6;

    // Stack pointer bank slots.
    localparam logic [1:0] SCR_SP_USER   = 2'h0;
    localparam logic [1:0] SCR_SP_INT    = 2'h1;
    localparam logic [1:0] SCR_SP_MASTER = 2'h2;
    localparam int unsigned SCR_SP_COUNT = 3;

    // Bus encodings used by the slave, and the width of the vector offset.
    localparam logic [2:0] SCR_HSIZE_BYTE = 3'h0;
    localparam logic [2:0] SCR_HSIZE_HALF = 3'h1;
    localparam int unsigned SCR_HPROT_PRIV = 1;
    localparam int unsigned SCR_VEC_OFF_W  = 10;

    ////////////////////////////////////////////////////////////////////////////////
    // Register selected by a bus address.
    typedef enum logic [2:0] {
        SCR_SEL_NONE   = 3'b000,
        SCR_SEL_STATUS = 3'b001,
        SCR_SEL_INT_SP = 3'b010,
        SCR_SEL_MST_SP = 3'b011,
        SCR_SEL_USR_SP = 3'b100,
        SCR_SEL_VBASE  = 3'b101,
        SCR_SEL_SRC_FC = 3'b110,
        SCR_SEL_DST_FC = 3'b111
    } scr_sel_type;

    // One memory access announced by the core.
    typedef struct packed {
        logic valid;
        logic program_ref;
        logic pc_relative;
        logic use_source_alt;
        logic use_dest_alt;
    } scr_access_type;

    // Condition code byte contents.
    typedef struct packed {
        logic extend;
        logic negative;
        logic zero;
        logic overflow;
        logic carry;
    } scr_cc_type;

    // Maps a byte address to the register it selects.
    function automatic scr_sel_type scr_decode(input logic [31:0] addr);
        scr_sel_type sel;
        sel = SCR_SEL_NONE;
        if (addr[31:8] == 24'h00_0000) begin
            case (addr[7:0])
                SCR_OFF_STATUS: sel = SCR_SEL_STATUS;
                SCR_OFF_INT_SP: sel = SCR_SEL_INT_SP;
                SCR_OFF_MST_SP: sel = SCR_SEL_MST_SP;
                SCR_OFF_USR_SP: sel = SCR_SEL_USR_SP;
                SCR_OFF_VBASE:  sel = SCR_SEL_VBASE;
                SCR_OFF_SRC_FC: sel = SCR_SEL_SRC_FC;
                SCR_OFF_DST_FC: sel = SCR_SEL_DST_FC;
                default:        sel = SCR_SEL_NONE;
            endcase
        end
        return sel;
    endfunction : scr_decode

    // Maps a stack pointer selection to its bank slot.
    function automatic logic [1:0] scr_sp_slot(input scr_sel_type sel);
        logic [1:0] slot;
        case (sel)
            SCR_SEL_INT_SP: slot = SCR_SP_INT;
            SCR_SEL_MST_SP: slot = SCR_SP_MASTER;
            default:        slot = SCR_SP_USER;
        endcase
        return slot;
    endfunction : scr_sp_slot

endpackage : scr_pkg

`default_nettype wire

//--- rtl/scr_regs.sv
// Supervisor control registers: status, stack pointers, vector base, alternate space codes.
// Assumes a zero-wait AHB-Lite master; hprot[1] high marks a supervisor access.
`default_nettype none

module scr_regs (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   ce,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [3:0]             hprot,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic      [31:0]            hrdata,
    input  wire logic                   cc_update,
    input  wire scr_pkg::scr_cc_type    cc_value,
    input  wire logic                   sp_write,
    input  wire logic [31:0]            sp_wdata,
    output logic      [31:0]            stack_address_register,
    output logic                        supervisor_mode,
    output logic                        master_mode,
    output logic                        trace_mode_hi,
    output logic                        trace_mode_lo,
    output logic      [2:0]             irq_mask,
    input  wire logic                   vector_req,
    input  wire logic [9:0]             vector_offset,
    output logic      [31:0]            vector_address,
    output logic                        vector_valid,
    input  wire scr_pkg::scr_access_type access_req,
    output logic      [2:0]             function_code,
    output logic                        function_valid
);
    import scr_pkg::*;

    logic        addr_take;
    scr_sel_type addr_sel;
    logic        addr_priv;
    logic        dp_valid_reg, dp_valid_next;
    logic        dp_write_reg, dp_write_next;
    logic        dp_priv_reg,  dp_priv_next;
    logic        dp_sp_reg,    dp_sp_next;
    logic [2:0]  dp_size_reg,  dp_size_next;
    scr_sel_type dp_sel_reg,   dp_sel_next;
    logic [31:0] rd_reg,       rd_next;
    logic        wr_go;
    logic [15:0] status_reg,   status_next;
    logic [31:0] vbase_reg,    vbase_next;
    logic [2:0]  src_fc_reg,   src_fc_next;
    logic [2:0]  dst_fc_reg,   dst_fc_next;
    logic [31:0] vec_reg,      vec_next;
    logic        vec_v_reg,    vec_v_next;
    logic [2:0]  fc_reg,       fc_next;
    logic        fc_v_reg,     fc_v_next;
    logic [1:0]  act_slot;
    logic        sp_bus_we;
    logic [31:0] sp_bus_data;
    logic [31:0] sp_rd_data;
    logic        is_program;

    ////////////////////////////////////////////////////////////////////////////////
    // Address phase; with the clock enable low the slave stalls instead of dropping a transfer.
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign addr_take = hsel && htrans[1] && hready && ce;
    assign addr_sel  = scr_decode(haddr);
    assign addr_priv = hprot[SCR_HPROT_PRIV];
    assign wr_go     = dp_valid_reg && dp_write_reg && ce;

    // Read data is captured at the address phase edge so the data phase carries no wait.
    always_comb begin
        dp_valid_next = addr_take;
        dp_write_next = dp_write_reg;
        dp_priv_next  = dp_priv_reg;
        dp_size_next  = dp_size_reg;
        dp_sel_next   = dp_sel_reg;
        dp_sp_next    = 1'b0;
        rd_next       = 32'h0000_0000;
        if (addr_take) begin
            dp_write_next = hwrite;
            dp_priv_next  = addr_priv;
            dp_size_next  = hsize;
            dp_sel_next   = addr_sel;
            case (addr_sel)
                SCR_SEL_STATUS: rd_next = addr_priv ? {16'h0000, status_reg}
                                                    : {24'h00_0000, status_reg[7:0]};
                SCR_SEL_INT_SP, SCR_SEL_MST_SP: dp_sp_next = addr_priv;
                SCR_SEL_USR_SP: dp_sp_next = 1'b1;
                SCR_SEL_VBASE:  rd_next = addr_priv ? vbase_reg : 32'h0000_0000;
                SCR_SEL_SRC_FC: rd_next = addr_priv ? {29'h0, src_fc_reg} : 32'h0000_0000;
                SCR_SEL_DST_FC: rd_next = addr_priv ? {29'h0, dst_fc_reg} : 32'h0000_0000;
                default:        rd_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_priv_reg  <= 1'b0;
            dp_size_reg  <= SCR_HSIZE_BYTE;
            dp_sel_reg   <= SCR_SEL_NONE;
            dp_sp_reg    <= 1'b0;
            rd_reg       <= 32'h0000_0000;
        end else if (ce) begin
            dp_valid_reg <= dp_valid_next;
            dp_write_reg <= dp_write_next;
            dp_priv_reg  <= dp_priv_next;
            dp_size_reg  <= dp_size_next;
            dp_sel_reg   <= dp_sel_next;
            dp_sp_reg    <= dp_sp_next;
            rd_reg       <= rd_next;
        end
    end

    assign hrdata = dp_sp_reg ? sp_rd_data : rd_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Stack pointers: the supervisor ones need privilege, no pointer takes a byte.
    always_comb begin
        sp_bus_we   = 1'b0;
        sp_bus_data = hwdata;
        if (wr_go && dp_size_reg != SCR_HSIZE_BYTE) begin
            case (dp_sel_reg)
                SCR_SEL_INT_SP, SCR_SEL_MST_SP: sp_bus_we = dp_priv_reg;
                SCR_SEL_USR_SP:                 sp_bus_we = 1'b1;
                default:                  sp_bus_we = 1'b0;
            endcase
        end
        // A halfword write to an address register is sign-extended, as for any address register.
        if (dp_size_reg == SCR_HSIZE_HALF) begin
            sp_bus_data = {{16{hwdata[15]}}, hwdata[15:0]};
        end
    end

    // The pointer behind the stack address register follows the mode and master bits.
    assign act_slot = !status_reg[SCR_ST_SUPER]  ? SCR_SP_USER   :
                      status_reg[SCR_ST_MASTER]  ? SCR_SP_MASTER : SCR_SP_INT;

    scr_sp_bank u_sp_bank (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .ce         (ce),
        .rd_slot    (scr_sp_slot(addr_sel)),
        .rd_data    (sp_rd_data),
        .act_slot   (act_slot),
        .act_data   (stack_address_register),
        .bus_we     (sp_bus_we),
        .bus_slot   (scr_sp_slot(dp_sel_reg)),
        .bus_wdata  (sp_bus_data),
        .core_we    (sp_write),
        .core_slot  (act_slot),
        .core_wdata (sp_wdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Status, vector base and space codes; a bus write to the status beats a core update.
    always_comb begin
        status_next = status_reg;
        vbase_next  = vbase_reg;
        src_fc_next = src_fc_reg;
        dst_fc_next = dst_fc_reg;
        if (cc_update) begin
            status_next[4:0] = cc_value;
        end
        if (wr_go) begin
            case (dp_sel_reg)
                SCR_SEL_STATUS: begin
                    if (dp_priv_reg && dp_size_reg != SCR_HSIZE_BYTE) begin
                        status_next = hwdata[15:0] & SCR_ST_MASK;
                    end else begin
                        status_next[7:0] = hwdata[7:0] & SCR_ST_MASK[7:0];
                    end
                end
                SCR_SEL_VBASE:  if (dp_priv_reg) vbase_next = hwdata;
                SCR_SEL_SRC_FC: if (dp_priv_reg) src_fc_next = hwdata[2:0];
                SCR_SEL_DST_FC: if (dp_priv_reg) dst_fc_next = hwdata[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= SCR_ST_RESET;
            vbase_reg  <= SCR_VBASE_RESET;
            src_fc_reg <= SCR_FC_RESET;
            dst_fc_reg <= SCR_FC_RESET;
        end else if (ce) begin
            status_reg <= status_next;
            vbase_reg  <= vbase_next;
            src_fc_reg <= src_fc_next;
            dst_fc_reg <= dst_fc_next;
        end
    end

    assign supervisor_mode = status_reg[SCR_ST_SUPER];
    assign master_mode     = status_reg[SCR_ST_MASTER];
    assign trace_mode_hi   = status_reg[SCR_ST_TRACE_HI];
    assign trace_mode_lo   = status_reg[SCR_ST_TRACE_LO];
    assign irq_mask        = status_reg[SCR_ST_IPM_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////////////
    // Vector address and function code, one registered answer per request.
    assign is_program = access_req.program_ref || access_req.pc_relative;

    always_comb begin
        vec_next   = vec_reg;
        vec_v_next = vector_req;
        fc_next    = fc_reg;
        fc_v_next  = access_req.valid;
        if (vector_req) begin
            vec_next = vbase_reg + {22'h00_0000, vector_offset};
        end
        if (access_req.valid) begin
            if (access_req.use_source_alt) begin
                fc_next = src_fc_reg;
            end else if (access_req.use_dest_alt) begin
                fc_next = dst_fc_reg;
            end else if (status_reg[SCR_ST_SUPER]) begin
                fc_next = is_program ? SCR_FC_SUPER_PROG : SCR_FC_SUPER_DATA;
            end else begin
                fc_next = is_program ? SCR_FC_USER_PROG : SCR_FC_USER_DATA;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vec_reg   <= SCR_VBASE_RESET;
            vec_v_reg <= 1'b0;
            fc_reg    <= SCR_FC_RESET;
            fc_v_reg  <= 1'b0;
        end else if (ce) begin
            vec_reg   <= vec_next;
            vec_v_reg <= vec_v_next;
            fc_reg    <= fc_next;
            fc_v_reg  <= fc_v_next;
        end
    end

    assign vector_address = vec_reg;
    assign vector_valid   = vec_v_reg;
    assign function_code  = fc_reg;
    assign function_valid = fc_v_valid_out();

    function automatic logic fc_v_valid_out();
        return fc_v_reg;
    endfunction : fc_v_valid_out

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the registers' behaviour.
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_cc_capture: assert property (
        ce && cc_update && !(wr_go && dp_sel_reg == SCR_SEL_STATUS)
        |=> status_reg[4:0] == $past(cc_value))
        else $error("condition codes not captured");
    a_user_upper: assert property (
        wr_go && !dp_priv_reg && dp_sel_reg == SCR_SEL_STATUS
        |=> $stable(status_reg[15:8]))
        else $error("user write changed supervisor status byte");
    a_user_vbr: assert property (
        wr_go && !dp_priv_reg && dp_sel_reg == SCR_SEL_VBASE |=> $stable(vbase_reg))
        else $error("user write reached the vector base");
    a_byte_sp: assert property (
        wr_go && dp_size_reg == SCR_HSIZE_BYTE |-> !sp_bus_we)
        else $error("byte write reached a stack pointer");
    a_sp_select: assert property (
        ce && status_reg[SCR_ST_SUPER] && !sp_write && !sp_bus_we ##1 ce && $stable(status_reg)
        |=> stack_address_register == $past(u_sp_bank.sp_reg[
            status_reg[SCR_ST_MASTER] ? SCR_SP_MASTER : SCR_SP_INT], 2))
        else $error("wrong supervisor stack pointer shown");
    a_vector_sum: assert property (
        ce && vector_req |=> vector_valid && vector_address == $past(vbase_reg)
            + {22'h00_0000, $past(vector_offset)})
        else $error("vector address is not base plus displacement");
    a_fc_source: assert property (
        ce && access_req.valid && access_req.use_source_alt |=> function_code == $past(src_fc_reg))
        else $error("source alternate code not used");
    a_fc_auto: assert property (
        ce && access_req.valid && !access_req.use_source_alt && !access_req.use_dest_alt
        |=> function_code[2] == $past(status_reg[SCR_ST_SUPER])
            && function_code[1] == $past(is_program) && function_code[0] == !$past(is_program))
        else $error("automatic function code wrong");
    a_src_code_width: assert property (
        wr_go && dp_priv_reg && dp_sel_reg == SCR_SEL_SRC_FC |=> src_fc_reg == $past(hwdata[2:0]))
        else $error("source space code not written");

    c_user_status: cover property (wr_go && !dp_priv_reg && dp_sel_reg == SCR_SEL_STATUS);
    c_vector:      cover property (ce && vector_req ##1 vector_valid);
    c_alt_dest:    cover property (ce && access_req.valid && access_req.use_dest_alt);
    c_master_sp:   cover property (status_reg[SCR_ST_SUPER] && status_reg[SCR_ST_MASTER]);

endmodule : scr_regs

`default_nettype wire

//--- rtl/scr_sp_bank.sv
// Bank of the three stack pointers with two registered read ports.
// Assumes the caller arbitrates privilege; the core write wins over the bus write.
`default_nettype none

module scr_sp_bank (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic [1:0]  rd_slot,
    output logic      [31:0] rd_data,
    input  wire logic [1:0]  act_slot,
    output logic      [31:0] act_data,
    input  wire logic        bus_we,
    input  wire logic [1:0]  bus_slot,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        core_we,
    input  wire logic [1:0]  core_slot,
    input  wire logic [31:0] core_wdata
);
    import scr_pkg::*;

    logic [31:0] sp_reg  [SCR_SP_COUNT];
    logic [31:0] sp_next [SCR_SP_COUNT];
    logic [31:0] rd_reg;
    logic [31:0] rd_next;
    logic [31:0] act_reg;
    logic [31:0] act_next;

    ////////////////////////////////////////////////////////////////////////////////
    // One slot per stack pointer; the core port is checked last so it wins a clash.
    for (genvar i = 0; i < SCR_SP_COUNT; i++) begin : g_slot
        always_comb begin
            sp_next[i] = sp_reg[i];
            if (bus_we && bus_slot == 2'(i)) begin
                sp_next[i] = bus_wdata;
            end
            if (core_we && core_slot == 2'(i)) begin
                sp_next[i] = core_wdata;
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                sp_reg[i] <= SCR_SP_RESET;
            end else if (ce) begin
                sp_reg[i] <= sp_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read ports; the unused fourth slot reads as zero.
    always_comb begin
        rd_next  = (rd_slot < 2'(SCR_SP_COUNT)) ? sp_reg[rd_slot] : 32'h0000_0000;
        act_next = (act_slot < 2'(SCR_SP_COUNT)) ? sp_reg[act_slot] : 32'h0000_0000;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_reg  <= SCR_SP_RESET;
            act_reg <= SCR_SP_RESET;
        end else if (ce) begin
            rd_reg  <= rd_next;
            act_reg <= act_next;
        end
    end

    assign rd_data  = rd_reg;
    assign act_data = act_reg;

endmodule : scr_sp_bank

`default_nettype wire

//--- verification/scr_regs_tb.sv
// Self-checking bench for the supervisor control register block.
// Assumes scr_pkg and scr_regs compile first; the bench is the only AHB-Lite master.
`default_nettype none

module scr_regs_tb import scr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////////////
    logic           hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]    haddr = '0, hwdata = '0, sp_wdata = '0, rd;
    logic [1:0]     htrans = 2'h0;
    logic [2:0]     hsize = 3'h2;
    logic [3:0]     hprot = 4'h3;
    logic           cc_update = 1'b0, sp_write = 1'b0, vector_req = 1'b0;
    logic [9:0]     vector_offset = '0;
    scr_cc_type     cc_value = '0;
    scr_access_type access_req = '0;
    logic           hreadyout, hresp, master_mode, vector_valid, function_valid;
    logic           supervisor_mode, trace_mode_hi, trace_mode_lo;
    logic [31:0]    hrdata, stack_address_register, vector_address;
    logic [2:0]     function_code, irq_mask;
    int             error_cnt = 0, checked = 0, cyc = 0;

    // Clock of 40 ns; the slave's hreadyout is fed back as the bus hready.
    always #20 hclk = ~hclk;
    scr_regs uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cc_update(cc_update), .cc_value(cc_value), .sp_write(sp_write), .sp_wdata(sp_wdata),
        .stack_address_register(stack_address_register), .supervisor_mode(supervisor_mode),
        .master_mode(master_mode), .trace_mode_hi(trace_mode_hi),
        .trace_mode_lo(trace_mode_lo), .irq_mask(irq_mask),
        .vector_req(vector_req), .vector_offset(vector_offset), .vector_address(vector_address),
        .vector_valid(vector_valid), .access_req(access_req), .function_code(function_code),
        .function_valid(function_valid));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // A hang must not run forever, so a cycle ceiling closes the run.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One single transfer; called just after a rising edge, waits on hready both phases.
    task automatic bus(input logic w, input logic [7:0] a, input logic [2:0] sz,
                       input logic p, input logic [31:0] wd);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w; hsize <= sz;
        hprot <= {2'h0, p, 1'b1};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    // The active pointer output lags a status change by one further edge.
    task automatic sp_chk(input logic [31:0] exp);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk(stack_address_register, exp);
        @(posedge hclk);
    endtask : sp_chk

    task automatic fc(input logic [4:0] r, input logic [2:0] e);
        access_req <= scr_access_type'(r);
        @(posedge hclk);
        access_req <= '0;
        @(negedge hclk);
        chk({31'h0, function_valid}, 32'h1);
        chk({29'h0, function_code}, {29'h0, e});
        @(posedge hclk);
    endtask : fc

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        bus(1'b0, SCR_OFF_STATUS, 3'h2, 1'b1, '0); chk(rd, 32'h2700);
        chk({29'h0, irq_mask}, 32'h7);
        chk({31'h0, supervisor_mode}, 32'h1);
        chk({31'h0, hresp}, 32'h0);
        bus(1'b1, SCR_OFF_INT_SP, 3'h2, 1'b1, 32'h1111_2222);
        bus(1'b1, SCR_OFF_VBASE, 3'h2, 1'b1, 32'h0000_1000);
        bus(1'b1, SCR_OFF_SRC_FC, 3'h2, 1'b1, 32'hffff_fffb);
        bus(1'b1, SCR_OFF_DST_FC, 3'h2, 1'b1, 32'h0000_0004);
        bus(1'b1, SCR_OFF_INT_SP, 3'h0, 1'b1, 32'h0000_0055);
        bus(1'b0, SCR_OFF_INT_SP, 3'h2, 1'b1, '0); chk(rd, 32'h1111_2222);
        bus(1'b1, SCR_OFF_MST_SP, 3'h1, 1'b1, 32'h0000_8001);
        bus(1'b0, SCR_OFF_MST_SP, 3'h2, 1'b1, '0); chk(rd, 32'hffff_8001);
        bus(1'b0, SCR_OFF_SRC_FC, 3'h2, 1'b1, '0); chk(rd, 32'h3);
        bus(1'b0, SCR_OFF_INT_SP, 3'h2, 1'b0, '0); chk(rd, 32'h0);
        bus(1'b0, 8'h1c, 3'h2, 1'b1, '0); chk(rd, 32'h0);
    endtask : t_regs

    // User writes reach only the low byte; the master bit picks the pointer.
    task automatic t_status();
        bus(1'b1, SCR_OFF_STATUS, 3'h2, 1'b0, 32'hffff_ffff);
        bus(1'b0, SCR_OFF_STATUS, 3'h2, 1'b0, '0); chk(rd, 32'h1f);
        bus(1'b0, SCR_OFF_STATUS, 3'h2, 1'b1, '0); chk(rd, 32'h271f);
        bus(1'b1, SCR_OFF_STATUS, 3'h2, 1'b1, 32'hf000); sp_chk(32'hffff_8001);
        chk({31'h0, master_mode}, 32'h1);
        chk({30'h0, trace_mode_hi, trace_mode_lo}, 32'h3);
        bus(1'b1, SCR_OFF_STATUS, 3'h2, 1'b1, 32'h2000); sp_chk(32'h1111_2222);
        chk({30'h0, trace_mode_hi, trace_mode_lo}, 32'h0);
    endtask : t_status

    task automatic t_cc_vec();
        cc_value <= scr_cc_type'(5'h15); cc_update <= 1'b1;
        @(posedge hclk);
        cc_update <= 1'b0;
        @(posedge hclk);
        bus(1'b0, SCR_OFF_STATUS, 3'h2, 1'b1, '0); chk(rd, 32'h2015);
        // With the clock enable low a core update must be frozen out.
        ce <= 1'b0; cc_value <= scr_cc_type'(5'h0a); cc_update <= 1'b1;
        @(posedge hclk);
        ce <= 1'b1; cc_update <= 1'b0;
        @(posedge hclk);
        bus(1'b0, SCR_OFF_STATUS, 3'h2, 1'b1, '0); chk(rd, 32'h2015);
        vector_offset <= 10'h3fc; vector_req <= 1'b1;
        @(posedge hclk);
        vector_req <= 1'b0;
        @(negedge hclk);
        chk({31'h0, vector_valid}, 32'h1);
        chk(vector_address, 32'h0000_13fc);
        @(posedge hclk);
    endtask : t_cc_vec

    // Supervisor automatic codes by reference kind, then the alternate registers, then user automatic codes.
    task automatic t_codes();
        fc(5'h10, 3'h5); fc(5'h18, 3'h6); fc(5'h14, 3'h6);
        fc(5'h12, 3'h3); fc(5'h11, 3'h4);
        bus(1'b1, SCR_OFF_STATUS, 3'h2, 1'b1, 32'h0); sp_chk(32'h0);
        fc(5'h10, 3'h1); fc(5'h14, 3'h2);
    endtask : t_codes

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_status();
        t_cc_vec();
        t_codes();
        finish_test();
    end
endmodule : scr_regs_tb

`default_nettype wire
